// ### rtl/ncos_pkg.sv
// Purpose: shared constants and types for the nibble cpu opcode slice
// Assumes: one opcode is presented per cycle by an outside fetch unit
// Notes:   all widths and opcodes used by more than one file live here
//
// Behaviour
// - call pushes program counter plus two, then jumps to twelve-bit address
// - carry clear opcode forces carry to zero and steps the program counter, nothing else changes
// - bcd adjust adds six and sets carry when acc above nine or carry
// - accumulator decrement subtracts one, carry untouched
// - 0001nnn1 decrements working register nnn zero to four, carry untouched
// - decrement memory nibble at second pointer pair, carry untouched
// - interrupt off opcode blocks timer and external interrupts
// - interrupt on opcode permits timer and external interrupts
// - halt opcode advances program counter by two and stops the clock
// - port read opcodes copy port s or port p into accumulator
// - accumulator increment adds one, carry untouched
// - 0001nnn0 increments working register nnn zero to four, carry untouched

`default_nettype none

package ncos_pkg;

  // opcodes of this slice
  localparam logic [7:0]  OPC_CARRY_CLEAR = 8'h2a;
  localparam logic [7:0]  OPC_BCD_ADJUST  = 8'h36;
  localparam logic [7:0]  OPC_ACC_DEC     = 8'h3f;
  localparam logic [7:0]  OPC_ACC_INC     = 8'h31;
  localparam logic [7:0]  OPC_MEM2_DEC    = 8'h0f;
  localparam logic [7:0]  OPC_INT_OFF     = 8'h2d;
  localparam logic [7:0]  OPC_INT_ON      = 8'h2c;
  localparam logic [7:0]  OPC_HALT_B0     = 8'h37;
  localparam logic [7:0]  OPC_HALT_B1     = 8'h3e;
  localparam logic [7:0]  OPC_IN_S        = 8'h33;
  localparam logic [7:0]  OPC_IN_P        = 8'h34;
  localparam logic [3:0]  OPC_CALL_TOP    = 4'hf;
  localparam logic [3:0]  OPC_REG_TOP     = 4'h1;

  // field positions and sizes
  localparam int          REG_SEL_LSB     = 1;
  localparam int          REG_SEL_W       = 3;
  localparam int          NUM_WREG        = 5;
  localparam int          PC_W            = 12;
  localparam int          MEM_DEPTH       = 128;
  localparam int          MEM_AW          = 7;

  // arithmetic constants
  localparam logic [3:0]  BCD_LIMIT       = 4'h9;
  localparam logic [3:0]  BCD_CORR        = 4'h6;
  localparam logic [3:0]  NIB_ONE         = 4'h1;
  localparam logic [11:0] PC_STEP1        = 12'h001;
  localparam logic [11:0] PC_STEP2        = 12'h002;

  // reset values
  localparam logic [11:0] PC_RESET        = 12'h000;
  localparam logic [3:0]  NIB_RESET       = 4'h0;
  localparam logic        INT_EN_RESET    = 1'b0;

  typedef enum logic [3:0] {
    op_none, op_call, op_carry_clear, op_bcd_adjust, op_acc_dec, op_acc_inc,
    op_reg_dec, op_reg_inc, op_mem2_dec, op_int_off, op_int_on, op_halt,
    op_in_s, op_in_p
  } ncos_op_e;

endpackage

`default_nettype wire

// ### rtl/ncos_decode.sv
// Purpose: classify the current opcode bytes into one operation
// Assumes: both instruction bytes are valid together
// Notes:   unknown opcodes map to op_none
`timescale 1ns/10ps
`default_nettype none

module ncos_decode
(
  input  wire logic [7:0]       byte0,
  input  wire logic [7:0]       byte1,
  output var ncos_pkg::ncos_op_e op,
  output logic      [2:0]       reg_sel
);

  // register group select sits in bits three to one
  assign reg_sel = byte0[ncos_pkg::REG_SEL_LSB +: ncos_pkg::REG_SEL_W];

  // opcode classification
  always_comb
  begin
    op = ncos_pkg::op_none;
    if (byte0[7:4] == ncos_pkg::OPC_CALL_TOP)
      op = ncos_pkg::op_call;
    else if (byte0[7:4] == ncos_pkg::OPC_REG_TOP && reg_sel < 3'(ncos_pkg::NUM_WREG))
      op = byte0[0] ? ncos_pkg::op_reg_dec : ncos_pkg::op_reg_inc;
    else
    begin
      case (byte0)
        ncos_pkg::OPC_CARRY_CLEAR: op = ncos_pkg::op_carry_clear;
        ncos_pkg::OPC_BCD_ADJUST:  op = ncos_pkg::op_bcd_adjust;
        ncos_pkg::OPC_ACC_DEC:     op = ncos_pkg::op_acc_dec;
        ncos_pkg::OPC_ACC_INC:     op = ncos_pkg::op_acc_inc;
        ncos_pkg::OPC_MEM2_DEC:    op = ncos_pkg::op_mem2_dec;
        ncos_pkg::OPC_INT_OFF:     op = ncos_pkg::op_int_off;
        ncos_pkg::OPC_INT_ON:      op = ncos_pkg::op_int_on;
        ncos_pkg::OPC_IN_S:        op = ncos_pkg::op_in_s;
        ncos_pkg::OPC_IN_P:        op = ncos_pkg::op_in_p;
        ncos_pkg::OPC_HALT_B0:
          op = (byte1 == ncos_pkg::OPC_HALT_B1) ? ncos_pkg::op_halt : ncos_pkg::op_none;
        default:                   op = ncos_pkg::op_none;
      endcase
    end
  end

endmodule // ncos_decode

`default_nettype wire

// ### rtl/ncos_nib_alu.sv
// Purpose: four-bit increment, decrement and bcd adjust
// Assumes: operand is already muxed by the caller
// Notes:   results wrap modulo sixteen
`timescale 1ns/10ps
`default_nettype none

module ncos_nib_alu
(
  input  wire ncos_pkg::ncos_op_e op,
  input  wire logic [3:0]         operand,
  input  wire logic               carry_in,
  output logic      [3:0]         result,
  output logic                    carry_out
);

  // one arithmetic step per operation
  always_comb
  begin
    result    = operand;
    carry_out = carry_in;
    case (op)
      ncos_pkg::op_acc_inc, ncos_pkg::op_reg_inc:
        result = 4'(operand + ncos_pkg::NIB_ONE);
      ncos_pkg::op_acc_dec, ncos_pkg::op_reg_dec, ncos_pkg::op_mem2_dec:
        result = 4'(operand - ncos_pkg::NIB_ONE);
      ncos_pkg::op_bcd_adjust:
        if (operand > ncos_pkg::BCD_LIMIT || carry_in)
        begin
          result    = 4'(operand + ncos_pkg::BCD_CORR);
          carry_out = 1'b1;
        end
      default: ;
    endcase
  end

endmodule // ncos_nib_alu

`default_nettype wire

// ### rtl/ncos_core.sv
// Purpose: execute the slice's opcodes on acc, carry, working regs, memory
// Assumes: fetch unit shows both bytes at pc while instr_valid is high
// Notes:   one instruction per cycle; halt holds until wake_req
`timescale 1ns/10ps
`default_nettype none

module ncos_core
#(
  parameter int MEM_DEPTH = ncos_pkg::MEM_DEPTH
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr_byte0,
  input  wire logic [7:0]  instr_byte1,
  input  wire logic [3:0]  port_s_lines,
  input  wire logic [3:0]  port_p_lines,
  input  wire logic        wake_req,
  input  wire logic [6:0]  dbg_addr,
  output logic      [11:0] pc_r,
  output logic      [11:0] stack_r,
  output logic      [3:0]  acc_r,
  output logic             carry_flag,
  output logic      [19:0] wregs_r,
  output logic             int_enable_r,
  output logic             clk_stop_r,
  output logic      [3:0]  dbg_data_r,
  output logic             instr_taken,
  output logic             unknown_op
);

  typedef struct packed {
    logic [11:0]     pc;
    logic [11:0]     stack;
    logic [3:0]      acc;
    logic            carry;
    logic [4:0][3:0] wreg;
    logic            int_en;
    logic            halted;
    logic [3:0]      dbg;
  } ncos_state_s;

  ncos_state_s          state_r;
  ncos_state_s          state_nxt;
  ncos_pkg::ncos_op_e   op;
  logic [2:0]           reg_sel;
  logic                 exec;
  logic [3:0]           alu_in;
  logic [3:0]           alu_res;
  logic                 alu_carry;
  logic [6:0]           mem_addr;
  logic [3:0]           mem_rd;
  logic                 mem_wr;
  logic [3:0]           sel_val;
  logic [3:0]           mem_r [MEM_DEPTH];

  // opcode classification
  ncos_decode u_decode
  (
    .byte0   (instr_byte0),
    .byte1   (instr_byte1),
    .op      (op),
    .reg_sel (reg_sel)
  );

  // shared four-bit arithmetic
  ncos_nib_alu u_alu
  (
    .op        (op),
    .operand   (alu_in),
    .carry_in  (state_r.carry),
    .result    (alu_res),
    .carry_out (alu_carry)
  );

  // instruction is executed only while the clock is running
  assign exec        = instr_valid && !state_r.halted;
  assign instr_taken = exec;
  assign unknown_op  = exec && (op == ncos_pkg::op_none);

  // second pointer pair forms the data memory address
  assign mem_addr = {state_r.wreg[3][2:0], state_r.wreg[2]};
  assign mem_rd   = mem_r[mem_addr];
  assign sel_val  = state_r.wreg[reg_sel];

  // operand select for the alu
  always_comb
  begin
    case (op)
      ncos_pkg::op_reg_inc, ncos_pkg::op_reg_dec: alu_in = sel_val;
      ncos_pkg::op_mem2_dec:                      alu_in = mem_rd;
      default:                                    alu_in = state_r.acc;
    endcase
  end

  // next-state for the whole slice
  always_comb
  begin
    state_nxt     = state_r;
    mem_wr        = 1'b0;
    state_nxt.dbg = mem_r[dbg_addr];
    if (state_r.halted && wake_req)
      state_nxt.halted = 1'b0;
    if (exec)
    begin
      state_nxt.pc = 12'(state_r.pc + ncos_pkg::PC_STEP1);
      case (op)
        ncos_pkg::op_call:
        begin
          state_nxt.stack = 12'(state_r.pc + ncos_pkg::PC_STEP2);
          state_nxt.pc    = {instr_byte0[3:0], instr_byte1};
        end
        ncos_pkg::op_carry_clear: state_nxt.carry = 1'b0;
        ncos_pkg::op_bcd_adjust:
        begin
          state_nxt.acc   = alu_res;
          state_nxt.carry = alu_carry;
        end
        ncos_pkg::op_acc_dec:     state_nxt.acc = alu_res;
        ncos_pkg::op_acc_inc:     state_nxt.acc = alu_res;
        ncos_pkg::op_reg_dec:     state_nxt.wreg[reg_sel] = alu_res;
        ncos_pkg::op_reg_inc:     state_nxt.wreg[reg_sel] = alu_res;
        ncos_pkg::op_mem2_dec:    mem_wr = 1'b1;
        ncos_pkg::op_int_off:     state_nxt.int_en = 1'b0;
        ncos_pkg::op_int_on:      state_nxt.int_en = 1'b1;
        ncos_pkg::op_halt:
        begin
          state_nxt.pc     = 12'(state_r.pc + ncos_pkg::PC_STEP2);
          state_nxt.halted = 1'b1;
        end
        ncos_pkg::op_in_s:        state_nxt.acc = port_s_lines;
        ncos_pkg::op_in_p:        state_nxt.acc = port_p_lines;
        default: ;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r        <= '0;
      state_r.pc     <= ncos_pkg::PC_RESET;
      state_r.stack  <= ncos_pkg::PC_RESET;
      state_r.acc    <= ncos_pkg::NIB_RESET;
      state_r.int_en <= ncos_pkg::INT_EN_RESET;
    end
    else
      state_r <= state_nxt;
  end

  // data memory, written by the pointer-pair decrement
  // cleared under reset: the decrement reads before it writes, and an
  // unknown nibble would spread into every later read of that address
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
        mem_r[i] <= ncos_pkg::NIB_RESET;
    end
    else if (mem_wr)
      mem_r[mem_addr] <= alu_res;
  end

  // outputs straight from state flops
  assign pc_r         = state_r.pc;
  assign stack_r      = state_r.stack;
  assign acc_r        = state_r.acc;
  assign carry_flag   = state_r.carry;
  assign wregs_r      = state_r.wreg;
  assign int_enable_r = state_r.int_en;
  assign clk_stop_r   = state_r.halted;
  assign dbg_data_r   = state_r.dbg;

  // checks next to the logic they guard
  AST_CALL: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_call |=>
      pc_r == {$past(instr_byte0[3:0]), $past(instr_byte1)} &&
      stack_r == 12'($past(pc_r) + 12'h002))
    else $error("call did not push pc plus two and jump");

  AST_CARRY_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_carry_clear |=> !carry_flag && $stable(acc_r))
    else $error("carry clear failed or touched acc");

  AST_BCD_ADJUST: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_bcd_adjust |=>
      (($past(acc_r) > 4'h9 || $past(carry_flag)) ?
        (carry_flag && acc_r == 4'($past(acc_r) + 4'h6)) :
        ($stable(acc_r) && $stable(carry_flag))))
    else $error("bcd adjust result wrong");

  AST_ACC_DEC: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_acc_dec |=>
      acc_r == 4'($past(acc_r) - 4'h1) && $stable(carry_flag))
    else $error("acc decrement wrong");

  AST_REG_DEC: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_reg_dec |=>
      state_r.wreg[$past(reg_sel)] == 4'($past(sel_val) - 4'h1) && $stable(carry_flag))
    else $error("register decrement wrong");

  AST_MEM2_DEC: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_mem2_dec |=>
      mem_r[$past(mem_addr)] == 4'($past(mem_rd) - 4'h1) && $stable(carry_flag))
    else $error("memory decrement wrong");

  AST_INT_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_int_off |=> !int_enable_r)
    else $error("interrupts not disabled");

  AST_INT_ON: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_int_on |=> int_enable_r)
    else $error("interrupts not enabled");

  AST_HALT: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_halt |=>
      clk_stop_r && pc_r == 12'($past(pc_r) + 12'h002) && !instr_taken)
    else $error("halt did not stop or advance pc by two");

  AST_PORT_READ: assert property (@(posedge clk) disable iff (!rst_b)
    exec && (op == ncos_pkg::op_in_s || op == ncos_pkg::op_in_p) |=>
      acc_r == ($past(op == ncos_pkg::op_in_s) ? $past(port_s_lines) : $past(port_p_lines)))
    else $error("port read wrong");

  AST_ACC_INC: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_acc_inc |=>
      acc_r == 4'($past(acc_r) + 4'h1) && $stable(carry_flag))
    else $error("acc increment wrong");

  AST_REG_INC: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op == ncos_pkg::op_reg_inc |=>
      state_r.wreg[$past(reg_sel)] == 4'($past(sel_val) + 4'h1) && $stable(carry_flag))
    else $error("register increment wrong");

  AST_PC_STEP: assert property (@(posedge clk) disable iff (!rst_b)
    exec && op != ncos_pkg::op_call && op != ncos_pkg::op_halt |=>
      pc_r == 12'($past(pc_r) + 12'h001))
    else $error("single-byte step wrong");

  // reset and hold checks: stack, carry, acc, working regs and interrupt enable move only under their own opcodes,
  // so a decode slip that hits the wrong field is caught here
  AST_RESET: assert property (@(posedge clk)
    !rst_b |=> pc_r == ncos_pkg::PC_RESET && stack_r == ncos_pkg::PC_RESET &&
      acc_r == ncos_pkg::NIB_RESET && !carry_flag && wregs_r == 20'h00000 &&
      int_enable_r == ncos_pkg::INT_EN_RESET && !clk_stop_r)
    else $error("state not cleared by reset");

  AST_STACK_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !(exec && op == ncos_pkg::op_call) |=> $stable(stack_r))
    else $error("stack changed without a call");

  AST_CARRY_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !(exec && op inside {ncos_pkg::op_carry_clear, ncos_pkg::op_bcd_adjust}) |=>
      $stable(carry_flag))
    else $error("carry changed by an opcode that must leave it alone");

  AST_ACC_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !(exec && op inside {ncos_pkg::op_bcd_adjust, ncos_pkg::op_acc_dec,
      ncos_pkg::op_acc_inc, ncos_pkg::op_in_s, ncos_pkg::op_in_p}) |=>
      $stable(acc_r))
    else $error("acc changed by an opcode that must leave it alone");

  AST_WREG_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !(exec && op inside {ncos_pkg::op_reg_inc, ncos_pkg::op_reg_dec}) |=> $stable(wregs_r))
    else $error("working register changed without a register opcode");

  AST_INT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !(exec && op inside {ncos_pkg::op_int_off, ncos_pkg::op_int_on}) |=>
      $stable(int_enable_r))
    else $error("interrupt enable changed on its own");

  AST_UNKNOWN: assert property (@(posedge clk) disable iff (!rst_b)
    unknown_op |=> $stable(acc_r) && $stable(carry_flag) && $stable(wregs_r) &&
      $stable(stack_r) && $stable(int_enable_r) && !clk_stop_r)
    else $error("opcode outside the slice changed state");

  AST_REG_RANGE: assert property (@(posedge clk) disable iff (!rst_b)
    exec && instr_byte0[7:4] == ncos_pkg::OPC_REG_TOP &&
      reg_sel >= 3'(ncos_pkg::NUM_WREG) |-> unknown_op)
    else $error("register opcode above the last working register executed");

  AST_HALT_PAIR: assert property (@(posedge clk) disable iff (!rst_b)
    exec && instr_byte0 == ncos_pkg::OPC_HALT_B0 &&
      instr_byte1 != ncos_pkg::OPC_HALT_B1 |=> !clk_stop_r)
    else $error("halt first byte alone stopped the clock");

  AST_REFUSED: assert property (@(posedge clk) disable iff (!rst_b)
    clk_stop_r && !wake_req |=>
      clk_stop_r && $stable(pc_r) && $stable(acc_r) && $stable(wregs_r))
    else $error("halted core executed an instruction");

  AST_WAKE: assert property (@(posedge clk) disable iff (!rst_b)
    clk_stop_r && wake_req |=> !clk_stop_r && $stable(pc_r))
    else $error("wake request did not restart the clock");

  AST_DBG: assert property (@(posedge clk) disable iff (!rst_b)
    rst_b |=> dbg_data_r == $past(mem_r[dbg_addr]))
    else $error("observed memory nibble wrong");

endmodule // ncos_core

`default_nettype wire

// ### tb/ncos_core_tb_top.sv
// Purpose: self-checking bench for the nibble cpu opcode slice core
// Assumes: bench acts as fetch unit; inputs change on the falling clock edge
// Notes:   expected state is kept in e_* variables and updated by each scenario
`timescale 1ns/10ps
`default_nettype none

module ncos_core_tb_top;
  logic        clk          = 1'b0;
  logic        rst_b        = 1'b0;
  logic        instr_valid  = 1'b0;
  logic        wake_req     = 1'b0;
  logic [7:0]  instr_byte0  = 8'h00;
  logic [7:0]  instr_byte1  = 8'h00;
  logic [3:0]  port_s_lines = 4'h0;
  logic [3:0]  port_p_lines = 4'h0;
  logic [6:0]  dbg_addr     = 7'h00;
  logic [11:0] pc_r;
  logic [11:0] stack_r;
  logic [3:0]  acc_r;
  logic [3:0]  dbg_data_r;
  logic [19:0] wregs_r;
  logic        carry_flag;
  logic        int_enable_r;
  logic        clk_stop_r;
  logic        instr_taken;
  logic        unknown_op;
  logic [11:0] e_pc         = 12'h000;
  logic [11:0] e_stack      = 12'h000;
  logic [3:0]  e_acc        = 4'h0;
  logic [19:0] e_regs       = 20'h00000;
  logic        e_c          = 1'b0;
  logic        e_ie         = 1'b0;
  logic        e_stop       = 1'b0;
  int          fails        = 0;
  int          checked      = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  ncos_core i_ncos_core
  (
    .clk          (clk),
    .rst_b        (rst_b),
    .instr_valid  (instr_valid),
    .instr_byte0  (instr_byte0),
    .instr_byte1  (instr_byte1),
    .port_s_lines (port_s_lines),
    .port_p_lines (port_p_lines),
    .wake_req     (wake_req),
    .dbg_addr     (dbg_addr),
    .pc_r         (pc_r),
    .stack_r      (stack_r),
    .acc_r        (acc_r),
    .carry_flag   (carry_flag),
    .wregs_r      (wregs_r),
    .int_enable_r (int_enable_r),
    .clk_stop_r   (clk_stop_r),
    .dbg_data_r   (dbg_data_r),
    .instr_taken  (instr_taken),
    .unknown_op   (unknown_op)
  );

  // single compare for every kind of result, zero-extended to 20 bits
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // compare all architectural state except data memory against the expected copy
  task automatic check_all();
    chk({8'h00, pc_r}, {8'h00, e_pc}, "pc");
    chk({8'h00, stack_r}, {8'h00, e_stack}, "stack");
    chk({16'h0000, acc_r}, {16'h0000, e_acc}, "acc");
    chk({19'h0, carry_flag}, {19'h0, e_c}, "carry");
    chk(wregs_r, e_regs, "wregs");
    chk({19'h0, int_enable_r}, {19'h0, e_ie}, "int enable");
    chk({19'h0, clk_stop_r}, {19'h0, e_stop}, "clock stop");
  endtask

  // present one instruction for one edge; pc expectation advances by one unless the clock is stopped
  task automatic exec(input logic [7:0] b0, input logic [7:0] b1, input logic unk);
    @(negedge clk);
    instr_byte0 = b0;
    instr_byte1 = b1;
    instr_valid = 1'b1;
    #10;
    chk({19'h0, instr_taken}, {19'h0, !e_stop}, "taken");
    if (!e_stop)
    begin
      chk({19'h0, unknown_op}, {19'h0, unk}, "unknown flag");
      e_pc = e_pc + 12'h001;
    end
    @(negedge clk);
    instr_valid = 1'b0;
  endtask

  // port reads, bcd adjust in all branches, carry clear
  task automatic t_acc();
    port_s_lines = 4'hb;
    port_p_lines = 4'h9;
    exec(ncos_pkg::OPC_IN_S, 8'h00, 1'b0);
    e_acc = 4'hb;
    check_all();
    exec(ncos_pkg::OPC_BCD_ADJUST, 8'h00, 1'b0);
    e_acc = 4'h1;
    e_c = 1'b1;
    check_all();
    exec(ncos_pkg::OPC_BCD_ADJUST, 8'h00, 1'b0);
    e_acc = 4'h7;
    check_all();
    exec(ncos_pkg::OPC_CARRY_CLEAR, 8'h00, 1'b0);
    e_c = 1'b0;
    check_all();
    exec(ncos_pkg::OPC_IN_P, 8'h00, 1'b0);
    e_acc = 4'h9;
    exec(ncos_pkg::OPC_BCD_ADJUST, 8'h00, 1'b0);
    check_all();
    port_p_lines = 4'ha;
    exec(ncos_pkg::OPC_IN_P, 8'h00, 1'b0);
    exec(ncos_pkg::OPC_BCD_ADJUST, 8'h00, 1'b0);
    e_acc = 4'h0;
    e_c = 1'b1;
    check_all();
  endtask

  // accumulator and register inc/dec wrap with carry held at one
  task automatic t_incdec();
    exec(ncos_pkg::OPC_ACC_DEC, 8'h00, 1'b0);
    e_acc = 4'hf;
    check_all();
    exec(ncos_pkg::OPC_ACC_INC, 8'h00, 1'b0);
    e_acc = 4'h0;
    check_all();
    for (int n = 0; n < 5; n++)
    begin
      exec({4'h1, n[2:0], 1'b1}, 8'h00, 1'b0);
      e_regs[n*4+:4] = 4'hf;
      check_all();
      exec({4'h1, n[2:0], 1'b0}, 8'h00, 1'b0);
      exec({4'h1, n[2:0], 1'b0}, 8'h00, 1'b0);
      e_regs[n*4+:4] = 4'h1;
      check_all();
    end
    exec(8'h1b, 8'h00, 1'b1);
    check_all();
    dbg_addr = 7'h11;                        // pointer pair r3:r2 = 1:1
    exec(ncos_pkg::OPC_MEM2_DEC, 8'h00, 1'b0);
    check_all();
    @(negedge clk);
    chk({16'h0000, dbg_data_r}, 20'h0000f, "memory dec");
    exec(ncos_pkg::OPC_MEM2_DEC, 8'h00, 1'b0);
    @(negedge clk);
    chk({16'h0000, dbg_data_r}, 20'h0000e, "memory dec again");
  endtask

  // interrupt gate on and off, then two calls including the top address
  task automatic t_int_call();
    exec(ncos_pkg::OPC_INT_ON, 8'h00, 1'b0);
    e_ie = 1'b1;
    check_all();
    exec(ncos_pkg::OPC_INT_OFF, 8'h00, 1'b0);
    e_ie = 1'b0;
    check_all();
    exec(8'hf1, 8'h23, 1'b0);
    e_stack = e_pc + 12'h001;
    e_pc = 12'h123;
    check_all();
    exec(8'hff, 8'hff, 1'b0);
    e_stack = 12'h125;
    e_pc = 12'hfff;
    check_all();
    exec(ncos_pkg::OPC_ACC_INC, 8'h00, 1'b0);
    e_acc = 4'h1;
    check_all();
  endtask

  // halt: pc+2, instructions refused, wake, then a broken second byte
  task automatic t_halt();
    int k;
    exec(ncos_pkg::OPC_HALT_B0, ncos_pkg::OPC_HALT_B1, 1'b0);
    e_pc = e_pc + 12'h001;
    e_stop = 1'b1;
    check_all();
    exec(ncos_pkg::OPC_ACC_INC, 8'h00, 1'b0);
    check_all();
    wake_req = 1'b1;
    k = 0;
    while (clk_stop_r !== 1'b0 && k < 4)
    begin
      @(negedge clk);
      k++;
    end
    wake_req = 1'b0;
    e_stop = 1'b0;
    chk({19'h0, clk_stop_r}, 20'h00000, "wake");
    if (clk_stop_r !== 1'b0)
      summarize();                           // wake bound used up
    exec(ncos_pkg::OPC_HALT_B0, 8'h00, 1'b1);
    check_all();
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog against a hung run
  initial
  begin
    #2000000;
    fails++;
    summarize();
  end

  // main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    check_all();
    t_acc();
    t_incdec();
    t_int_call();
    t_halt();
    summarize();
  end
endmodule // ncos_core_tb_top

`default_nettype wire
